// ==== logic/hmsr_top.v ====
// Two-wire slave, register bank and control of the hardware monitor
`timescale 1ns/1ps
`include "hmsr_regs.vh"

// Summary of operation
// - Slave only; never drives the serial clock or starts a transfer.
// - Read with no pointer byte returns the register at the held pointer.
// - Slave address defaults 01011 plus pins; low two bits always follow pins.
// - Clock or data low beyond 35 ms returns the serial logic to idle.
// - Serial clock only steps the interface; monitor runs on internal clock.
// - Power-up loads listed defaults, control register to 08h.
// - Value memory is never reset by power-up or soft soft_init_bit.
// - Reset pin low at least 50 ns returns registers to defaults.
// - Control bit 7 reinitializes listed registers, not the slave address, intrusion clear or DAC.
// - Soft init bit clears itself after the soft_init_bit.
// - At power-up converter stopped and alert clear set.
// - Control bit 0 low halts monitoring; high starts it.
// - Control bit 1 high enables the alert output.
// - Control bit 3 forces alert inactive and pauses monitoring.
// - Control bit 4 drives a 20 ms low pulse on the reset pin.
// - Intrusion clear bit drives a 20 ms low pulse on the intrusion pin.
// - Start bit high with alert clear low begins the measurement loop.
// - Loop order: temp, core2, 12V, 5V, 3.3V, core1, 2.5V, fan1, fan2.
// - DAC output updates at the stop of the DAC write; powers up all ones.
module hmsr_top #(
	parameter [31:0] TIMEOUT_CYC = `HMSR_TIMEOUT_CYC,
	parameter [31:0] PULSE_CYC = `HMSR_PULSE_CYC,
	parameter [31:0] SLOT_CYC = `HMSR_SLOT_CYC
) (
	input wire clk,
	input wire rst_b,
	input wire scl_in,
	input wire sda_in,
	output wire sda_out,
	output reg sda_oe,
	input wire slave_addr_pin_low,
	input wire slave_addr_pin_high,
	input wire [3:0] id_pins_low,
	input wire id_pin_fifth,
	input wire reset_pin_in,
	output wire reset_pin_out,
	output wire reset_pin_oe,
	input wire intrusion_pin,
	output wire intrusion_pin_out,
	output wire intrusion_pin_oe,
	input wire [7:0] event_set_a,
	input wire [7:0] event_set_b,
	input wire [7:0] meas_result,
	output wire alert_b,
	output reg [7:0] analog_level_output,
	output reg monitor_run,
	output reg [3:0] meas_slot,
	output reg meas_strobe
);

// ----------------------------------------
// Input synchronisers
// ----------------------------------------
reg [1:0] scl_s_q;
reg [1:0] sda_s_q;
reg [1:0] pin_s_q;
reg [4:0] id_s_q0;
reg [4:0] id_s_q1;
reg scl_d1_q;
reg sda_d1_q;

always @(posedge clk or negedge rst_b) begin
	if (!rst_b) begin
		scl_s_q <= 2'h3;
		sda_s_q <= 2'h3;
		pin_s_q <= 2'h0;
		id_s_q0 <= 5'h00;
		id_s_q1 <= 5'h00;
		scl_d1_q <= 1'b1;
		sda_d1_q <= 1'b1;
	end else begin
		scl_s_q <= {scl_s_q[0], scl_in};
		sda_s_q <= {sda_s_q[0], sda_in};
		pin_s_q <= {pin_s_q[0], slave_addr_pin_high};
		id_s_q0 <= {id_pin_fifth, id_pins_low};
		id_s_q1 <= id_s_q0;
		scl_d1_q <= scl_s_q[1];
		sda_d1_q <= sda_s_q[1];
	end
end

reg [1:0] pin_lo_s_q;
always @(posedge clk or negedge rst_b) begin
	if (!rst_b) begin
		pin_lo_s_q <= 2'h0;
	end else begin
		pin_lo_s_q <= {pin_lo_s_q[0], slave_addr_pin_low};
	end
end

wire scl = scl_s_q[1];
wire sda = sda_s_q[1];
wire [1:0] addr_pins = {pin_s_q[1], pin_lo_s_q[1]};
wire scl_rise = scl & ~scl_d1_q;
wire scl_fall = ~scl & scl_d1_q;
wire start_cond = scl & scl_d1_q & ~sda & sda_d1_q;
wire stop_cond = scl & scl_d1_q & sda & ~sda_d1_q;

// ----------------------------------------
// Bus timeout
// ----------------------------------------
reg [31:0] low_cnt_q;
wire timeout = (low_cnt_q >= TIMEOUT_CYC);

always @(posedge clk or negedge rst_b) begin
	if (!rst_b) begin
		low_cnt_q <= 32'h0;
	end else if (scl & sda) begin
		low_cnt_q <= 32'h0;
	end else if (!timeout) begin
		low_cnt_q <= low_cnt_q + 32'h1;
	end
end

// ----------------------------------------
// Serial slave
// ----------------------------------------
localparam [2:0] ST_IDLE = 3'h0;
localparam [2:0] ST_ADDR = 3'h1;
localparam [2:0] ST_ACK = 3'h2;
localparam [2:0] ST_WR = 3'h3;
localparam [2:0] ST_RD = 3'h4;
localparam [2:0] ST_RACK = 3'h5;

reg [2:0] st_q;
reg [7:0] sh_q;
reg [3:0] bit_q;
reg rw_q;
reg ptr_phase_q;
reg [7:0] ptr_q;
reg wr_pulse_q;
reg [7:0] wr_data_q;
reg [7:0] tx_q;
reg sda_low_q;
reg dac_pend_q;
reg [7:0] slave_hi_q;
wire [7:0] rd_data;
wire [6:0] my_addr = {slave_hi_q[6:2], addr_pins};

assign sda_out = 1'b0;

// Drive low only on acknowledge or a zero data bit; clock is never driven
always @* begin
	sda_oe = sda_low_q;
end

always @(posedge clk or negedge rst_b) begin
	if (!rst_b) begin
		st_q <= ST_IDLE;
		sh_q <= 8'h00;
		bit_q <= 4'h0;
		rw_q <= 1'b0;
		ptr_phase_q <= 1'b0;
		ptr_q <= 8'h00;
		wr_pulse_q <= 1'b0;
		wr_data_q <= 8'h00;
		tx_q <= 8'h00;
		sda_low_q <= 1'b0;
	end else begin
		wr_pulse_q <= 1'b0;
		if (timeout || stop_cond) begin
			st_q <= ST_IDLE;
			sda_low_q <= 1'b0;
		end else if (start_cond) begin
			st_q <= ST_ADDR;
			bit_q <= 4'h0;
			sda_low_q <= 1'b0;
		end else begin
			case (st_q)
			ST_ADDR, ST_WR: begin
				if (scl_rise) begin
					sh_q <= {sh_q[6:0], sda};
					bit_q <= bit_q + 4'h1;
				end
				if (scl_fall && bit_q == 4'h8) begin
					bit_q <= 4'h0;
					if (st_q == ST_ADDR) begin
						rw_q <= sh_q[0];
						ptr_phase_q <= ~sh_q[0];
						sda_low_q <= (sh_q[7:1] == my_addr);
						tx_q <= rd_data;
						st_q <= (sh_q[7:1] == my_addr) ? ST_ACK : ST_IDLE;
					end else begin
						sda_low_q <= 1'b1;
						st_q <= ST_ACK;
						if (ptr_phase_q) begin
							ptr_q <= sh_q;
							ptr_phase_q <= 1'b0;
						end else begin
							wr_pulse_q <= 1'b1;
							wr_data_q <= sh_q;
						end
					end
				end
			end
			ST_ACK: begin
				if (scl_fall) begin
					if (rw_q) begin
						st_q <= ST_RD;
						sda_low_q <= ~tx_q[7];
						tx_q <= {tx_q[6:0], 1'b0};
						bit_q <= 4'h1;
					end else begin
						st_q <= ST_WR;
						sda_low_q <= 1'b0;
					end
				end
			end
			ST_RD: begin
				if (scl_fall) begin
					if (bit_q == 4'h8) begin
						sda_low_q <= 1'b0;
						st_q <= ST_RACK;
					end else begin
						sda_low_q <= ~tx_q[7];
						tx_q <= {tx_q[6:0], 1'b0};
						bit_q <= bit_q + 4'h1;
					end
				end
			end
			ST_RACK: begin
				// Host NACK ends the read; pointer is not advanced
				if (scl_rise) begin
					st_q <= sda ? ST_IDLE : ST_RACK;
				end
				if (scl_fall) begin
					tx_q <= {rd_data[6:0], 1'b0};
					sda_low_q <= ~rd_data[7];
					bit_q <= 4'h1;
					st_q <= ST_RD;
				end
			end
			default: begin
				st_q <= ST_IDLE;
			end
			endcase
		end
	end
end

// ----------------------------------------
// Register bank
// ----------------------------------------
reg [7:0] ctrl_q;
reg [7:0] flags_a_q;
reg [7:0] flags_b_q;
reg [7:0] mask_a_q;
reg [7:0] mask_b_q;
reg [7:0] intr_clr_q;
reg [3:0] fandiv_q;
reg [7:0] tcfg_q;
reg [7:0] ext_a_q;
reg [7:0] ext_b_q;
reg [7:0] dac_q;
reg [7:0] vmem_q [0:31];
reg [31:0] rpulse_cnt_q;
reg [31:0] ipulse_cnt_q;
wire soft_init = ctrl_q[`HMSR_CTRL_INIT];
wire wr_ctrl = wr_pulse_q && ptr_q == `HMSR_ADDR_CTRL;
wire wr_slot = meas_strobe;

// Reset pin input resets, in addition to power-on rst_b
reg [1:0] rpin_s_q;
reg [1:0] own_drv_q;
always @(posedge clk or negedge rst_b) begin
	if (!rst_b) begin
		rpin_s_q <= 2'h3;
		own_drv_q <= 2'h0;
	end else begin
		rpin_s_q <= {rpin_s_q[0], reset_pin_in};
		own_drv_q <= {own_drv_q[0], reset_pin_oe};
	end
end
// Own pulse echoes through the synchroniser; ignore the pin until it clears
wire pin_rst = ~rpin_s_q[1] && !reset_pin_oe && own_drv_q == 2'h0;

always @(posedge clk or negedge rst_b) begin
	if (!rst_b) begin
		ctrl_q <= `HMSR_RST_CTRL;
		flags_a_q <= `HMSR_RST_FLAGS;
		flags_b_q <= `HMSR_RST_FLAGS;
		mask_a_q <= `HMSR_RST_MASK;
		mask_b_q <= `HMSR_RST_MASK;
		intr_clr_q <= `HMSR_RST_INTR_CLR;
		fandiv_q <= `HMSR_RST_FANDIV_HI;
		tcfg_q <= `HMSR_RST_TCFG;
		ext_a_q <= `HMSR_RST_EXT_A;
		ext_b_q <= `HMSR_RST_EXT_B;
		slave_hi_q <= {1'b0, `HMSR_RST_SLAVE_HI, 2'h0};
		dac_q <= `HMSR_RST_DAC;
	end else if (pin_rst || soft_init) begin
		ctrl_q <= `HMSR_RST_CTRL;
		// Event in the same cycle as an init survives
		flags_a_q <= `HMSR_RST_FLAGS | event_set_a;
		flags_b_q <= `HMSR_RST_FLAGS | event_set_b;
		mask_a_q <= `HMSR_RST_MASK;
		mask_b_q <= `HMSR_RST_MASK;
		fandiv_q <= `HMSR_RST_FANDIV_HI;
		tcfg_q <= `HMSR_RST_TCFG;
		ext_a_q <= `HMSR_RST_EXT_A;
		ext_b_q <= `HMSR_RST_EXT_B;
		if (pin_rst) begin
			slave_hi_q <= {1'b0, `HMSR_RST_SLAVE_HI, 2'h0};
			intr_clr_q <= `HMSR_RST_INTR_CLR;
			dac_q <= `HMSR_RST_DAC;
		end
	end else begin
		// Hardware set wins over any same-cycle clear
		flags_a_q <= flags_a_q | event_set_a;
		flags_b_q <= flags_b_q | event_set_b;
		if (ctrl_q[`HMSR_CTRL_RST_PULSE] && rpulse_cnt_q == 32'h1) begin
			ctrl_q[`HMSR_CTRL_RST_PULSE] <= 1'b0;
		end
		if (intr_clr_q[`HMSR_INTR_CLR_BIT] && ipulse_cnt_q == 32'h1) begin
			intr_clr_q[`HMSR_INTR_CLR_BIT] <= 1'b0;
		end
		if (wr_pulse_q) begin
			if (ptr_q == `HMSR_ADDR_CTRL) begin
				ctrl_q <= wr_data_q;
			end else if (ptr_q == `HMSR_ADDR_MASK_A) begin
				mask_a_q <= wr_data_q;
			end else if (ptr_q == `HMSR_ADDR_MASK_B) begin
				mask_b_q <= wr_data_q;
			end else if (ptr_q == `HMSR_ADDR_INTR_CLR) begin
				intr_clr_q <= wr_data_q;
			end else if (ptr_q == `HMSR_ADDR_FANDIV) begin
				fandiv_q <= wr_data_q[7:4];
			end else if (ptr_q == `HMSR_ADDR_SLAVE) begin
				slave_hi_q <= {1'b0, wr_data_q[6:2], 2'h0};
			end else if (ptr_q == `HMSR_ADDR_TCFG) begin
				tcfg_q <= wr_data_q;
			end else if (ptr_q == `HMSR_ADDR_EXT_A) begin
				ext_a_q <= wr_data_q;
			end else if (ptr_q == `HMSR_ADDR_EXT_B) begin
				ext_b_q <= wr_data_q;
			end else if (ptr_q == `HMSR_ADDR_DAC) begin
				dac_q <= wr_data_q;
			end
		end
	end
end

// Value memory has no reset so contents survive every soft_init_bit
always @(posedge clk) begin
	if (wr_pulse_q && ptr_q >= `HMSR_ADDR_VMEM_LO && ptr_q <= `HMSR_ADDR_VMEM_HI) begin
		vmem_q[ptr_q[4:0]] <= wr_data_q;
	end else if (wr_slot) begin
		vmem_q[{1'b0, meas_slot}] <= meas_result;
	end
end

assign rd_data =
	(ptr_q == `HMSR_ADDR_CTRL) ? ctrl_q :
	(ptr_q == `HMSR_ADDR_FLAGS_A) ? flags_a_q :
	(ptr_q == `HMSR_ADDR_FLAGS_B) ? flags_b_q :
	(ptr_q == `HMSR_ADDR_MASK_A) ? mask_a_q :
	(ptr_q == `HMSR_ADDR_MASK_B) ? mask_b_q :
	(ptr_q == `HMSR_ADDR_INTR_CLR) ? intr_clr_q :
	(ptr_q == `HMSR_ADDR_FANDIV) ? {fandiv_q, id_s_q1[3:0]} :
	(ptr_q == `HMSR_ADDR_SLAVE) ? {1'b0, slave_hi_q[6:2], addr_pins} :
	(ptr_q == `HMSR_ADDR_ID4) ? {`HMSR_RST_ID4_HI, id_s_q1[4]} :
	(ptr_q == `HMSR_ADDR_TCFG) ? tcfg_q :
	(ptr_q == `HMSR_ADDR_EXT_A) ? ext_a_q :
	(ptr_q == `HMSR_ADDR_EXT_B) ? ext_b_q :
	(ptr_q == `HMSR_ADDR_DAC) ? dac_q :
	(ptr_q >= `HMSR_ADDR_VMEM_LO && ptr_q <= `HMSR_ADDR_VMEM_HI) ? vmem_q[ptr_q[4:0]] :
	8'h00;

// ----------------------------------------
// DAC update at stop
// ----------------------------------------
always @(posedge clk or negedge rst_b) begin
	if (!rst_b) begin
		dac_pend_q <= 1'b0;
		analog_level_output <= `HMSR_RST_DAC;
	end else begin
		if (wr_pulse_q && ptr_q == `HMSR_ADDR_DAC) begin
			dac_pend_q <= 1'b1;
		end else if (stop_cond || timeout) begin
			dac_pend_q <= 1'b0;
		end
		if (stop_cond && dac_pend_q) begin
			analog_level_output <= dac_q;
		end else if (pin_rst) begin
			analog_level_output <= `HMSR_RST_DAC;
		end
	end
end

// ----------------------------------------
// Pulse outputs
// ----------------------------------------
always @(posedge clk or negedge rst_b) begin
	if (!rst_b) begin
		rpulse_cnt_q <= 32'h0;
		ipulse_cnt_q <= 32'h0;
	end else begin
		if (wr_ctrl && wr_data_q[`HMSR_CTRL_RST_PULSE] && rpulse_cnt_q == 32'h0) begin
			rpulse_cnt_q <= PULSE_CYC;
		end else if (rpulse_cnt_q != 32'h0) begin
			rpulse_cnt_q <= rpulse_cnt_q - 32'h1;
		end
		if (wr_pulse_q && ptr_q == `HMSR_ADDR_INTR_CLR && wr_data_q[`HMSR_INTR_CLR_BIT] &&
			ipulse_cnt_q == 32'h0) begin
			ipulse_cnt_q <= PULSE_CYC;
		end else if (ipulse_cnt_q != 32'h0) begin
			ipulse_cnt_q <= ipulse_cnt_q - 32'h1;
		end
	end
end

assign reset_pin_out = 1'b0;
assign reset_pin_oe = (rpulse_cnt_q != 32'h0);
assign intrusion_pin_out = 1'b0;
assign intrusion_pin_oe = (ipulse_cnt_q != 32'h0);

// ----------------------------------------
// Alert and monitoring loop
// ----------------------------------------
wire alert_any = |(flags_a_q & ~mask_a_q) | |(flags_b_q & ~mask_b_q);
assign alert_b = ~(alert_any & ctrl_q[`HMSR_CTRL_ALERT_EN] &
	~ctrl_q[`HMSR_CTRL_ALERT_CLR]);

reg [31:0] slot_cnt_q;
// Slot order equals value memory order, so slot index is the address
always @(posedge clk or negedge rst_b) begin
	if (!rst_b) begin
		monitor_run <= 1'b0;
		meas_slot <= 4'h0;
		meas_strobe <= 1'b0;
		slot_cnt_q <= 32'h0;
	end else begin
		monitor_run <= ctrl_q[`HMSR_CTRL_START] & ~ctrl_q[`HMSR_CTRL_ALERT_CLR];
		meas_strobe <= 1'b0;
		if (!monitor_run) begin
			slot_cnt_q <= 32'h0;
		end else if (slot_cnt_q >= SLOT_CYC - 32'h1) begin
			slot_cnt_q <= 32'h0;
			meas_strobe <= 1'b1;
			meas_slot <= (meas_slot == `HMSR_NUM_SLOTS - 1) ? 4'h0 : meas_slot + 4'h1;
		end else begin
			slot_cnt_q <= slot_cnt_q + 32'h1;
		end
	end
end

endmodule // hmsr_top

// ==== include/hmsr_regs.vh ====
// Register offsets, field positions, reset values and timing counts of the monitor register bank
`ifndef HMSR_REGS_VH
`define HMSR_REGS_VH
`define HMSR_ADDR_DAC 8'h19
`define HMSR_ADDR_VMEM_LO 8'h20
`define HMSR_ADDR_VMEM_HI 8'h3F
`define HMSR_ADDR_CTRL 8'h40
`define HMSR_ADDR_FLAGS_A 8'h41
`define HMSR_ADDR_FLAGS_B 8'h42
`define HMSR_ADDR_MASK_A 8'h43
`define HMSR_ADDR_MASK_B 8'h44
`define HMSR_ADDR_INTR_CLR 8'h46
`define HMSR_ADDR_FANDIV 8'h47
`define HMSR_ADDR_SLAVE 8'h48
`define HMSR_ADDR_ID4 8'h49
`define HMSR_ADDR_TCFG 8'h4B
`define HMSR_ADDR_EXT_A 8'h4C
`define HMSR_ADDR_EXT_B 8'h4D
`define HMSR_RST_CTRL 8'h08
`define HMSR_RST_FLAGS 8'h00
`define HMSR_RST_MASK 8'h00
`define HMSR_RST_INTR_CLR 8'h00
`define HMSR_RST_FANDIV_HI 4'h5
`define HMSR_RST_SLAVE_HI 5'h0B
`define HMSR_RST_ID4_HI 7'h40
`define HMSR_RST_TCFG 8'h01
`define HMSR_RST_EXT_A 8'h44
`define HMSR_RST_EXT_B 8'h00
`define HMSR_RST_DAC 8'hFF
`define HMSR_CTRL_START 0
`define HMSR_CTRL_ALERT_EN 1
`define HMSR_CTRL_ALERT_CLR 3
`define HMSR_CTRL_RST_PULSE 4
`define HMSR_CTRL_INIT 7
`define HMSR_INTR_CLR_BIT 7
`define HMSR_CLK_MHZ 250
`define HMSR_TIMEOUT_MS 35
`define HMSR_PULSE_MS 20
`define HMSR_SLOT_MS 44
`define HMSR_TIMEOUT_CYC (`HMSR_TIMEOUT_MS * 1000 * `HMSR_CLK_MHZ)
`define HMSR_PULSE_CYC (`HMSR_PULSE_MS * 1000 * `HMSR_CLK_MHZ)
`define HMSR_SLOT_CYC (`HMSR_SLOT_MS * 1000 * `HMSR_CLK_MHZ)
`define HMSR_NUM_SLOTS 9
`endif

// ==== test/hmsr_monitor.sv ====
// Property checker bound to the monitor register bank top module
`timescale 1ns/1ps
// ----------------------------------------
// Port checker
// ----------------------------------------
module hmsr_monitor #(
	parameter [31:0] TIMEOUT_CYC = 32'hC8,
	parameter [31:0] PULSE_CYC = 32'h32
) (
	input wire clk,
	input wire rst_b,
	input wire scl_in,
	input wire sda_in,
	input wire sda_out,
	input wire sda_oe,
	input wire reset_pin_oe,
	input wire intrusion_pin_oe,
	input wire alert_b,
	input wire [7:0] analog_level_output,
	input wire monitor_run,
	input wire [3:0] meas_slot,
	input wire meas_strobe
);
	logic [31:0] rp_q;
	logic [31:0] ci_q;
	logic [31:0] low_q;
	// Full width so a long pulse never wraps the count
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rp_q <= 32'h0;
			ci_q <= 32'h0;
			low_q <= 32'h0;
		end else begin
			rp_q <= reset_pin_oe ? rp_q + 32'h1 : 32'h0;
			ci_q <= intrusion_pin_oe ? ci_q + 32'h1 : 32'h0;
			low_q <= scl_in ? 32'h0 : low_q + 32'h1;
		end
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);
	sda_low_only_a:
		assert property (sda_out == 1'b0) else $error("data driven high");
	ack_clock_low_a:
		assert property ($rose(sda_oe) |-> !scl_in) else $error("data pulled with clock high");
	boot_state_a:
		assert property ($rose(rst_b) |=> alert_b && !monitor_run && analog_level_output == 8'hFF)
		else $error("wrong state after reset");
	halt_no_sample_a:
		assert property (meas_strobe |-> monitor_run || $past(monitor_run))
		else $error("sample while halted");
	slot_range_a:
		assert property (meas_slot <= 4'h8) else $error("slot out of range");
	slot_order_a:
		assert property ($changed(meas_slot) && monitor_run && $past(monitor_run) |->
			meas_slot == ($past(meas_slot) == 4'h8 ? 4'h0 : $past(meas_slot) + 4'h1))
		else $error("slot order broken");
	reset_pulse_len_a:
		assert property ($fell(reset_pin_oe) |-> rp_q == PULSE_CYC) else $error("reset pulse length");
	intr_pulse_len_a:
		assert property ($fell(intrusion_pin_oe) |-> ci_q == PULSE_CYC) else $error("intrusion pulse length");
	bus_timeout_a:
		assert property (low_q > TIMEOUT_CYC + 32'h8 |-> !sda_oe) else $error("no bus timeout");
	dac_at_stop_a:
		assert property ($changed(analog_level_output) |-> scl_in && sda_in)
		else $error("level changed inside frame");
endmodule // hmsr_monitor

bind hmsr_top hmsr_monitor #(.TIMEOUT_CYC(TIMEOUT_CYC), .PULSE_CYC(PULSE_CYC)) i_hmsr_monitor (
	.clk(clk), .rst_b(rst_b), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
	.sda_oe(sda_oe), .reset_pin_oe(reset_pin_oe), .intrusion_pin_oe(intrusion_pin_oe),
	.alert_b(alert_b), .analog_level_output(analog_level_output), .monitor_run(monitor_run),
	.meas_slot(meas_slot), .meas_strobe(meas_strobe));

// ==== test/hmsr_host.sv ====
// Two-wire bus host model driving the monitor's serial pins
`timescale 1ns/1ps
// ----------------------------------------
// Host model
// ----------------------------------------
module hmsr_host (
	output logic scl,
	output logic sda_drv,
	input wire logic sda
);
	logic [6:0] addr;
	logic acked;
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
		addr = 7'h2E;
		acked = 1'b1;
	end
	// Clock stands high between frames; the host owns it alone
	task automatic put(input logic b);
		sda_drv = b;
		#40 scl = 1'b1;
		#80 scl = 1'b0;
		#40;
	endtask
	task automatic start();
		sda_drv = 1'b1;
		#40 scl = 1'b1;
		#40 sda_drv = 1'b0;
		#40 scl = 1'b0;
		#40;
	endtask
	task automatic stop();
		sda_drv = 1'b0;
		#40 scl = 1'b1;
		#40 sda_drv = 1'b1;
		#80;
	endtask
	task automatic tx(input logic [7:0] d);
		for (int i = 7; i >= 0; i--) put(d[i]);
		sda_drv = 1'b1;
		#40 scl = 1'b1;
		acked = acked & (sda === 1'b0);
		#80 scl = 1'b0;
		#40;
	endtask
	task automatic rx(output logic [7:0] d);
		sda_drv = 1'b1;
		for (int i = 7; i >= 0; i--) begin
			#40 scl = 1'b1;
			d[i] = sda;
			#80 scl = 1'b0;
			#40;
		end
		put(1'b1);
	endtask
	task automatic wr(input logic [7:0] p, input logic [7:0] d);
		start();
		tx({addr, 1'b0});
		tx(p);
		tx(d);
		stop();
	endtask
	// Whole frames apart, so never faster than one result slot
	task automatic rd(output logic [7:0] d);
		start();
		tx({addr, 1'b1});
		rx(d);
		stop();
	endtask
	task automatic rdp(input logic [7:0] p, output logic [7:0] d);
		start();
		tx({addr, 1'b0});
		tx(p);
		start();
		tx({addr, 1'b1});
		rx(d);
		stop();
	endtask
endmodule // hmsr_host

// ==== test/hmsr_top_bench.sv ====
// Self-checking bench for the monitor register bank and serial slave
`timescale 1ns/1ps
module hmsr_top_bench;
	logic clk, rst_b, a_lo, a_hi, id5, rpin_drv, sda_out, sda_oe, rst_out, rst_oe;
	logic ci_out, ci_oe, alert_b, monitor_run, meas_strobe;
	logic [3:0] ids, meas_slot;
	logic [7:0] ev_a, ev_b, meas_result, analog_level_output, rd_v, rp_cnt, ci_cnt;
	wire scl, sda_drv;
	int bad_count, checked;
	logic [7:0] dp [10] = '{8'h40, 8'h41, 8'h42, 8'h43, 8'h44, 8'h46, 8'h4B, 8'h4C, 8'h4D, 8'h19};
	logic [7:0] dv [10] = '{8'h08, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h44, 8'h00, 8'hFF};
	wire sda = sda_drv & ~sda_oe;
	hmsr_host i_hmsr_host (.scl(scl), .sda_drv(sda_drv), .sda(sda));
	hmsr_top #(.TIMEOUT_CYC(32'h3E8), .PULSE_CYC(32'h32), .SLOT_CYC(32'h14)) i_hmsr_top (
		.clk(clk), .rst_b(rst_b), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
		.sda_oe(sda_oe), .slave_addr_pin_low(a_lo), .slave_addr_pin_high(a_hi),
		.id_pins_low(ids), .id_pin_fifth(id5), .reset_pin_in(rpin_drv & ~rst_oe),
		.reset_pin_out(rst_out), .reset_pin_oe(rst_oe), .intrusion_pin(~ci_oe),
		.intrusion_pin_out(ci_out), .intrusion_pin_oe(ci_oe), .event_set_a(ev_a),
		.event_set_b(ev_b), .meas_result(meas_result), .alert_b(alert_b),
		.analog_level_output(analog_level_output), .monitor_run(monitor_run),
		.meas_slot(meas_slot), .meas_strobe(meas_strobe));
	always #2 clk = ~clk;
	always @(negedge clk) meas_result <= {4'h8, meas_slot};
	always @(posedge clk) begin
		if (!rst_b) begin
			rp_cnt <= 8'h00;
			ci_cnt <= 8'h00;
		end else begin
			if (rst_oe === 1'b1) rp_cnt <= rp_cnt + 8'h01;
			if (ci_oe === 1'b1) ci_cnt <= ci_cnt + 8'h01;
		end
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rr(input logic [7:0] p, input logic [7:0] exp);
		logic [7:0] d;
		i_hmsr_host.rdp(p, d);
		chk(d, exp);
	endtask
	task automatic rc(input logic [7:0] exp);
		logic [7:0] d;
		i_hmsr_host.rd(d);
		chk(d, exp);
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// Whole run is near 78k cycles; this limit leaves some margin
	initial begin
		#380000;
		bad_count++;
		$display("MISMATCH at %0t: watchdog expired", $time);
		give_verdict();
	end
	initial begin
		{clk, rst_b, a_lo, a_hi, id5, rpin_drv} = 6'h07;
		{ids, ev_a, ev_b} = 20'hA_00_00;
		repeat (8) @(posedge clk);
		@(negedge clk) rst_b = 1'b1;
		repeat (3) @(negedge clk);
		for (int i = 0; i < 10; i++) rr(dp[i], dv[i]);
		rr(8'h47, 8'h5A);
		rr(8'h48, 8'h2E);
		rr(8'h49, 8'h81);
		$display("test defaults done");
		i_hmsr_host.wr(8'h43, 8'hA5);
		rc(8'hA5);
		rc(8'hA5);
		i_hmsr_host.wr(8'h41, 8'hFF);
		rr(8'h41, 8'h00);
		chk({7'h00, i_hmsr_host.acked}, 8'h01);
		@(negedge clk) a_hi = 1'b0;
		a_lo = 1'b1;
		i_hmsr_host.addr = 7'h2D;
		rr(8'h48, 8'h2D);
		i_hmsr_host.wr(8'h48, 8'h30);
		i_hmsr_host.addr = 7'h31;
		rr(8'h48, 8'h31);
		i_hmsr_host.addr = 7'h2D;
		i_hmsr_host.rd(rd_v);
		chk({7'h00, i_hmsr_host.acked}, 8'h00);
		i_hmsr_host.addr = 7'h31;
		$display("test address done");
		i_hmsr_host.wr(8'h19, 8'h5A);
		chk(analog_level_output, 8'h5A);
		i_hmsr_host.wr(8'h43, 8'hA4);
		i_hmsr_host.wr(8'h40, 8'h01);
		chk({7'h00, monitor_run}, 8'h01);
		repeat (400) @(negedge clk);
		for (int i = 0; i < 9; i++) rr(8'h20 + i[7:0], 8'h80 + i[7:0]);
		@(negedge clk) ev_a = 8'h01;
		@(negedge clk) ev_a = 8'h00;
		chk({7'h00, alert_b}, 8'h01);
		i_hmsr_host.wr(8'h40, 8'h03);
		chk({7'h00, alert_b}, 8'h00);
		@(negedge clk) ev_b = 8'h02;
		@(negedge clk) ev_b = 8'h00;
		rr(8'h42, 8'h02);
		i_hmsr_host.wr(8'h40, 8'h0B);
		chk({7'h00, alert_b}, 8'h01);
		chk({7'h00, monitor_run}, 8'h00);
		rr(8'h41, 8'h01);
		$display("test monitor done");
		i_hmsr_host.wr(8'h40, 8'h80);
		rr(8'h40, 8'h08);
		rr(8'h41, 8'h00);
		rr(8'h43, 8'h00);
		rr(8'h48, 8'h31);
		rr(8'h20, 8'h80);
		chk(analog_level_output, 8'h5A);
		$display("test soft init done");
		i_hmsr_host.wr(8'h40, 8'h18);
		repeat (100) @(negedge clk);
		chk(rp_cnt, 8'h32);
		chk({6'h00, rst_out, ci_out}, 8'h00);
		rr(8'h40, 8'h08);
		rr(8'h48, 8'h31);
		i_hmsr_host.wr(8'h46, 8'h80);
		repeat (100) @(negedge clk);
		chk(ci_cnt, 8'h32);
		rr(8'h46, 8'h00);
		@(negedge clk) rpin_drv = 1'b0;
		repeat (16) @(negedge clk);
		rpin_drv = 1'b1;
		repeat (8) @(negedge clk);
		chk(analog_level_output, 8'hFF);
		i_hmsr_host.addr = 7'h2D;
		rr(8'h48, 8'h2D);
		rr(8'h20, 8'h80);
		rr(8'h40, 8'h08);
		$display("test pulses done");
		i_hmsr_host.start();
		i_hmsr_host.tx({7'h2D, 1'b1});
		#100;
		chk({7'h00, sda_oe}, 8'h01);
		#4500;
		chk({7'h00, sda_oe}, 8'h00);
		i_hmsr_host.stop();
		rc(8'h08);
		$display("test timeout done");
		give_verdict();
	end
endmodule // hmsr_top_bench
